//--- hdl/fsc_pkg.sv
package fsc_pkg;
  // ------------
  // Register offsets
  // ------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_ISR    = 8'h08;
  localparam logic [7:0] OFS_IER    = 8'h0c;
  localparam logic [7:0] OFS_HEIGHT = 8'h10;
  localparam logic [7:0] OFS_WIDTH  = 8'h14;
  localparam logic [7:0] OFS_BUF0   = 8'h24;
  localparam logic [7:0] OFS_BUF1   = 8'h28;
  localparam logic [7:0] OFS_BUF2   = 8'h2c;
  localparam logic [7:0] OFS_BSIZE  = 8'h30;
  localparam logic [7:0] OFS_DEPTH  = 8'h34;
  // ------------
  // Field positions and reset values
  // ------------
  localparam int CB_EN     = 0;
  localparam int CB_MOT    = 1;
  localparam int CB_UPD    = 2;
  localparam int CB_CANCEL = 3;
  localparam int CB_FORCE  = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int IRQ_N      = 11;
  localparam int EXT_EVT_N  = 7;
  localparam int WDT_W      = 11;
  localparam int BSZ_W      = 24;
  localparam logic [1:0] DEP_12 = 2'h2;
  localparam int PAIR_W10   = 40;
  localparam int PAIR_W12   = 48;
  // ------------
  // Memory master
  // ------------
  localparam int BURST_LEN = 32;
  localparam logic [7:0] AXLEN_FIX = 8'h1f;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] RD_MAX_OUT = 2'h2;
  localparam logic [1:0] WR_ID = 2'h2;
  typedef enum logic [3:0] {
    WS_FILL = 4'b0001,
    WS_ADDR = 4'b0010,
    WS_DATA = 4'b0100,
    WS_RESP = 4'b1000
  } wst_t;
endpackage

//--- hdl/pair_word_packer.sv
`timescale 1ns/1ns
module pair_word_packer
  import fsc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // Mode
  input  wire logic        twelveBit,
  // Pair input
  input  wire logic        pairValid,
  input  wire logic [35:0] pixIn,
  input  wire logic [11:0] errIn,
  output logic             pairReady,
  // Word output
  output logic             wordValid,
  output logic [31:0]      wordData,
  input  wire logic        wordReady
);
  // ------------
  // Bit accumulator
  // ------------
  logic [79:0] acc_r;
  logic [6:0]  fill_r;
  logic [79:0] pairBits;
  logic [6:0]  pairLen;

  always_comb begin
    if (twelveBit) begin  // R3
      pairBits = {32'h0, errIn, pixIn};
      pairLen  = 7'(PAIR_W12);
    end else begin  // R2
      pairBits = {40'h0, errIn[9:0], pixIn[29:0]};
      pairLen  = 7'(PAIR_W10);
    end
  end

  assign pairReady = (fill_r < 7'd32);
  assign wordValid = (fill_r >= 7'd32);
  assign wordData  = acc_r[31:0];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc_r  <= 80'h0;
      fill_r <= 7'h0;
    end else if (clkEn) begin
      if (pairValid && pairReady) begin  // R21
        acc_r  <= acc_r | (pairBits << fill_r);
        fill_r <= fill_r + pairLen;
      end else if (wordValid && wordReady) begin
        acc_r  <= acc_r >> 32;
        fill_r <= fill_r - 7'd32;
      end
    end
  end
endmodule // pair_word_packer

//--- hdl/field_store_config_ctrl.sv
`timescale 1ns/1ns
// Operation
// R1: One write stream, two read streams.
// R2: Short depths pack four pairs in five words.
// R3: Twelve-bit packs two pairs in three words.
// R4: Software keeps line words whole.
// R5: Configuration shadowed into processing copies.
// R6: Global register holds force and disable.
// R7: Software edits copies, then requests update.
// R8: Pending update locks configuration registers.
// R9: Frame boundary copies pending values to shadows.
// R10: Cancel clears pending update at once.
// R11: Eleven events, sticky, enabled, cleared individually.
// R12: One register access at a time.
// R13: Simultaneous write served first, read stalled.
// R14: Unneeded optional bus signals left unconnected.
// R15: Motion mode stores stream in memory.
// R16: Rotating three field store.
// R17: Buffer bases and size set by software.
// R18: Memory port on its own clock; the code clocks it from ref_clk like the register port.
// R19: Three streams share one master port.
// R20: Memory data width parameter 32 to 256.
// R21: Interleave pixels and errors by depth.
// R22: Frame end advances buffer pointers.
// R23: Bursts fixed 32 beats, never narrow.
// R24: Read IDs 0/1, two outstanding, rready high.
// R25: Buffer size in words, 24 bits.
// R26: Write rotates 0,1,2; reads take previous two.
module field_store_config_ctrl
  import fsc_pkg::*;
#(
  parameter int DW = 64
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 clkEn,
  // Register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdData,
  // Video side
  input  wire logic                 frameEnd,
  input  wire logic [EXT_EVT_N-1:0] evtIn,
  input  wire logic                 pixValid,
  input  wire logic [35:0]          pixData,
  input  wire logic [11:0]          errData,
  output logic                      pixReady,
  output logic      [1:0]           rdValid,
  output logic      [DW-1:0]        rdData,
  // Configuration to processing
  output logic                      deintEnable,
  output logic                      motionEnable,
  output logic                      forceBypass,
  output logic      [WDT_W-1:0]     cfgWidth,
  output logic      [WDT_W-1:0]     cfgHeight,
  output logic      [1:0]           cfgDepth,
  output logic                      updPending,
  output logic                      irqOut,
  // Memory write channels
  output logic                      awvalid,
  input  wire logic                 awready,
  output logic      [31:0]          awaddr,
  output logic      [7:0]           awlen,
  output logic      [2:0]           awsize,
  output logic      [1:0]           awburst,
  output logic      [1:0]           awid,
  output logic                      wvalid,
  input  wire logic                 wready,
  output logic      [DW-1:0]        wdata,
  output logic      [DW/8-1:0]      wstrb,
  output logic                      wlast,
  input  wire logic                 bvalid,
  output logic                      bready,
  // Memory read channels
  output logic                      arvalid,
  input  wire logic                 arready,
  output logic      [31:0]          araddr,
  output logic      [7:0]           arlen,
  output logic      [2:0]           arsize,
  output logic      [1:0]           arburst,
  output logic      [1:0]           arid,
  input  wire logic                 rvalid,
  output logic                      rready,
  input  wire logic [DW-1:0]        rdata,
  input  wire logic [1:0]           rid,
  input  wire logic                 rlast
);
  localparam int WPB = DW / 32;
  localparam logic [25:0] BB = 26'(BURST_LEN * DW / 8);
  localparam logic [2:0] SZ = 3'($clog2(DW / 8));

  function automatic logic [1:0] prevIdx(input logic [1:0] i);
    prevIdx = (i == 2'd0) ? 2'd2 : i - 2'd1;
  endfunction

  function automatic logic [1:0] nextIdx(input logic [1:0] i);
    nextIdx = (i == 2'd2) ? 2'd0 : i + 2'd1;
  endfunction

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [4:0]       ctrl_r;
  logic             pending_r;
  logic [WDT_W-1:0] width_r, height_r, shWidth_r, shHeight_r;
  logic [1:0]       depth_r, shDepth_r;
  logic [31:0]      buf_r [3];
  logic [31:0]      shBuf_r [3];
  logic [BSZ_W-1:0] bsize_r, shBsize_r;
  logic [IRQ_N-1:0] isr_r, ier_r;
  logic [31:0]      rdData_r, rdMux;
  logic             rdDefer_r;
  logic [1:0]       wrIdx_r;
  logic             wrDone, motionOn, ctrlWr, apply, cancelW, updW, cfgWr;
  logic [IRQ_N-1:0] evts;

  assign ctrlWr   = regWr && (regAddr == OFS_CTRL);
  assign cancelW  = ctrlWr && regWrData[CB_CANCEL];
  assign updW     = ctrlWr && regWrData[CB_UPD];
  assign apply    = frameEnd && pending_r;
  assign cfgWr    = regWr && !pending_r;  // R8
  assign motionOn = ctrl_r[CB_EN] && ctrl_r[CB_MOT] && !ctrl_r[CB_FORCE];
  assign evts = {evtIn, wrDone, frameEnd && motionOn, cancelW && pending_r, apply};

  // Global register lives on the bus side and acts at once.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_r    <= CTRL_RST;
      pending_r <= 1'b0;
    end else if (clkEn) begin
      if (ctrlWr) begin
        ctrl_r <= {regWrData[CB_FORCE], 2'b00, regWrData[CB_MOT:CB_EN]};  // R6
      end
      if (cancelW) begin
        pending_r <= 1'b0;  // R10
      end else if (updW) begin
        pending_r <= 1'b1;  // R7
      end else if (apply) begin
        pending_r <= 1'b0;
      end
    end
  end

  // Bus-side copies, freely written unless an update is queued.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      width_r  <= '0;
      height_r <= '0;
      depth_r  <= 2'h0;
      bsize_r  <= '0;
      buf_r    <= '{default: 32'h0};
    end else if (clkEn && cfgWr) begin  // R7
      case (regAddr)
        OFS_WIDTH:  width_r  <= regWrData[WDT_W-1:0];
        OFS_HEIGHT: height_r <= regWrData[WDT_W-1:0];
        OFS_DEPTH:  depth_r  <= regWrData[1:0];
        OFS_BSIZE:  bsize_r  <= regWrData[BSZ_W-1:0];  // R25
        OFS_BUF0:   buf_r[0] <= regWrData;  // R17
        OFS_BUF1:   buf_r[1] <= regWrData;
        OFS_BUF2:   buf_r[2] <= regWrData;
        default:    ;
      endcase
    end
  end

  // Processing-side shadows, loaded only on a frame boundary.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      shWidth_r  <= '0;
      shHeight_r <= '0;
      shDepth_r  <= 2'h0;
      shBsize_r  <= '0;
      shBuf_r    <= '{default: 32'h0};
    end else if (clkEn && apply) begin  // R5 R9
      shWidth_r  <= width_r;
      shHeight_r <= height_r;
      shDepth_r  <= depth_r;
      shBsize_r  <= bsize_r;
      shBuf_r    <= buf_r;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      isr_r <= '0;
      ier_r <= '0;
    end else if (clkEn) begin
      if (regWr && regAddr == OFS_IER) begin
        ier_r <= regWrData[IRQ_N-1:0];
      end
      if (regWr && regAddr == OFS_ISR) begin
        isr_r <= (isr_r & ~regWrData[IRQ_N-1:0]) | evts;  // R11
      end else begin
        isr_r <= isr_r | evts;
      end
    end
  end

  always_comb begin
    case (regAddr)
      OFS_CTRL:   rdMux = {27'h0, ctrl_r};
      OFS_STAT:   rdMux = {29'h0, wrIdx_r, pending_r};
      OFS_ISR:    rdMux = {21'h0, isr_r};
      OFS_IER:    rdMux = {21'h0, ier_r};
      OFS_WIDTH:  rdMux = {21'h0, width_r};
      OFS_HEIGHT: rdMux = {21'h0, height_r};
      OFS_DEPTH:  rdMux = {30'h0, depth_r};
      OFS_BSIZE:  rdMux = {8'h0, bsize_r};
      OFS_BUF0:   rdMux = buf_r[0];
      OFS_BUF1:   rdMux = buf_r[1];
      OFS_BUF2:   rdMux = buf_r[2];
      default:    rdMux = 32'h0;
    endcase
  end

  // A read that meets a write is answered one cycle late.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdData_r  <= 32'h0;
      rdDefer_r <= 1'b0;
    end else if (clkEn) begin
      rdDefer_r <= regRd && regWr;  // R13
      if ((regRd && !regWr) || rdDefer_r) begin  // R12
        rdData_r <= rdMux;
      end else begin
        rdData_r <= 32'h0;
      end
    end
  end

  assign regRdData    = rdData_r;
  assign deintEnable  = ctrl_r[CB_EN];
  assign motionEnable = ctrl_r[CB_MOT];
  assign forceBypass  = ctrl_r[CB_FORCE];
  assign cfgWidth     = shWidth_r;
  assign cfgHeight    = shHeight_r;
  assign cfgDepth     = shDepth_r;
  assign updPending   = pending_r;
  assign irqOut       = |(isr_r & ier_r);

  // --------------------------------------------------------------------
  // Triple field rotation
  // --------------------------------------------------------------------
  logic [25:0] fieldBytes;
  logic [1:0]  rdIdx [2];

  assign fieldBytes = {shBsize_r, 2'b00};
  assign rdIdx[0]   = prevIdx(wrIdx_r);  // R26
  assign rdIdx[1]   = prevIdx(prevIdx(wrIdx_r));

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wrIdx_r <= 2'h0;
    end else if (clkEn && frameEnd && motionOn) begin
      wrIdx_r <= nextIdx(wrIdx_r);  // R16 R22 R26
    end
  end

  // --------------------------------------------------------------------
  // Write stream
  // --------------------------------------------------------------------
  wst_t        wst_r;
  logic [DW-1:0] mem_r [BURST_LEN];
  logic [DW-1:0] wData_r;
  logic [4:0]  beat_r;
  logic [3:0]  wSel_r;
  logic [25:0] wrOff_r;
  logic [31:0] awAddr_r;
  logic        wordValid, wordReady, pairReady;
  logic [31:0] word;

  pair_word_packer u_packer (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clkEn     (clkEn),
    .twelveBit (shDepth_r == DEP_12),  // R21
    .pairValid (pixValid && motionOn),  // R15
    .pixIn     (pixData),
    .errIn     (errData),
    .pairReady (pairReady),
    .wordValid (wordValid),
    .wordData  (word),
    .wordReady (wordReady)
  );

  assign pixReady  = motionOn ? pairReady : 1'b1;
  assign wordReady = (wst_r == WS_FILL);
  assign wrDone    = (wst_r == WS_RESP) && bvalid;

  // A whole burst is gathered before the address goes out.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wst_r    <= WS_FILL;
      beat_r   <= 5'h0;
      wSel_r   <= 4'h0;
      wData_r  <= '0;
      awAddr_r <= 32'h0;
    end else if (clkEn) begin
      case (wst_r)
        WS_FILL: if (wordValid) begin
          mem_r[beat_r][wSel_r*32 +: 32] <= word;
          if (wSel_r == 4'(WPB - 1)) begin
            wSel_r <= 4'h0;
            beat_r <= beat_r + 5'h1;
            if (beat_r == 5'(BURST_LEN - 1)) begin
              wst_r    <= WS_ADDR;
              awAddr_r <= shBuf_r[wrIdx_r] + 32'(wrOff_r);  // R1
            end
          end else begin
            wSel_r <= wSel_r + 4'h1;
          end
        end
        WS_ADDR: if (awready) begin
          wst_r   <= WS_DATA;
          wData_r <= mem_r[0];
        end
        WS_DATA: if (wready) begin
          beat_r  <= beat_r + 5'h1;
          wData_r <= mem_r[beat_r + 5'h1];
          if (beat_r == 5'(BURST_LEN - 1)) begin
            wst_r <= WS_RESP;
          end
        end
        WS_RESP: if (bvalid) begin
          wst_r <= WS_FILL;
        end
        default: wst_r <= WS_FILL;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wrOff_r <= 26'h0;
    end else if (clkEn) begin
      if (frameEnd) begin
        wrOff_r <= 26'h0;
      end else if (wst_r == WS_ADDR && awready) begin
        wrOff_r <= wrOff_r + BB;
      end
    end
  end

  // Lock, cache, prot and qos are absent.  R14
  assign awvalid = (wst_r == WS_ADDR);
  assign awaddr  = awAddr_r;
  assign awlen   = AXLEN_FIX;  // R23
  assign awsize  = SZ;
  assign awburst = BURST_INCR;
  assign awid    = WR_ID;  // R19
  assign wvalid  = (wst_r == WS_DATA);
  assign wdata   = wData_r;
  assign wstrb   = '1;
  assign wlast   = (wst_r == WS_DATA) && (beat_r == 5'(BURST_LEN - 1));
  assign bready  = (wst_r == WS_RESP);

  // --------------------------------------------------------------------
  // Read streams
  // --------------------------------------------------------------------
  logic        arValid_r, turn_r;
  logic [31:0] arAddr_r;
  logic [1:0]  arId_r;
  logic [25:0] rdOff_r [2];
  logic [1:0]  outs_r [2];
  logic [1:0]  rdValid_r;
  logic [DW-1:0] rData_r;
  logic        elig [2];
  logic        pick;

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      elig[s] = motionOn && (outs_r[s] < RD_MAX_OUT) && (rdOff_r[s] < fieldBytes);
    end
    pick = elig[turn_r] ? turn_r : !turn_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      arValid_r <= 1'b0;
      arAddr_r  <= 32'h0;
      arId_r    <= 2'h0;
      turn_r    <= 1'b0;
      rdOff_r   <= '{default: 26'h0};
      outs_r    <= '{default: 2'h0};
    end else if (clkEn) begin
      for (int s = 0; s < 2; s++) begin
        if (arValid_r && arready && arId_r == 2'(s)) begin
          if (!(rvalid && rlast && rid == 2'(s))) begin
            outs_r[s] <= outs_r[s] + 2'h1;  // R24
          end
        end else if (rvalid && rlast && rid == 2'(s)) begin
          outs_r[s] <= outs_r[s] - 2'h1;
        end
        if (frameEnd) begin
          rdOff_r[s] <= 26'h0;
        end else if (arValid_r && arready && arId_r == 2'(s)) begin
          rdOff_r[s] <= rdOff_r[s] + BB;
        end
      end
      if (arValid_r) begin
        if (arready) begin
          arValid_r <= 1'b0;
        end
      end else if (elig[pick] && !frameEnd) begin
        arValid_r <= 1'b1;
        arId_r    <= {1'b0, pick};  // R24
        arAddr_r  <= shBuf_r[rdIdx[pick]] + 32'(rdOff_r[pick]);
        turn_r    <= !pick;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdValid_r <= 2'h0;
      rData_r   <= '0;
    end else if (clkEn) begin
      rdValid_r <= {rvalid && rid == 2'h1, rvalid && rid == 2'h0};
      rData_r   <= rdata;  // R18
    end
  end

  assign arvalid = arValid_r;
  assign araddr  = arAddr_r;
  assign arlen   = AXLEN_FIX;
  assign arsize  = SZ;  // R20
  assign arburst = BURST_INCR;
  assign arid    = arId_r;
  assign rready  = 1'b1;
  assign rdValid = rdValid_r;
  assign rdData  = rData_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn || !clkEn);

  AST_LOCK: assert property (pending_r && regWr && regAddr == OFS_WIDTH |=> // R8
    width_r == $past(width_r)) else $error("width changed while pending");
  AST_SHADOW: assert property (frameEnd && pending_r && !updW |=> // R9
    !pending_r && shWidth_r == $past(width_r)) else $error("shadow not loaded");
  AST_CANCEL: assert property (cancelW |=> !pending_r) // R10
    else $error("cancel did not clear");
  AST_ISR: assert property (evts[0] |=> isr_r[0]) // R11
    else $error("event lost");
  AST_AWLEN: assert property (awvalid |-> awlen == 8'h1f && awsize == SZ) // R23
    else $error("bad write burst");
  AST_WLAST: assert property (wvalid && wready && wlast |=> bready && !wvalid) // R23
    else $error("wlast misplaced");
  AST_RDID: assert property (arvalid |-> arid < 2'h2 && outs_r[arid[0]] < 2'h2) // R24
    else $error("read id or outstanding bad");
  AST_ROT: assert property (frameEnd && motionOn |=> // R26
    wrIdx_r == nextIdx($past(wrIdx_r))) else $error("rotation wrong");
  AST_RDIDX: assert property (rdIdx[0] != wrIdx_r && rdIdx[1] != wrIdx_r) // R16
    else $error("read buffer equals write buffer");
  AST_AWHOLD: assert property (awvalid && !awready |=> awvalid && $stable(awaddr)) // R19
    else $error("address dropped");

  CVR_UPD: cover property (updW ##[1:50] apply);
  CVR_WR: cover property (wrDone);
  CVR_RD: cover property (rvalid && rlast && rid == 2'h1);
  CVR_CAN: cover property (cancelW && pending_r);
endmodule // field_store_config_ctrl

//--- bench/mem_slave_model.sv
`timescale 1ns/1ns
// ------------
// Memory slave with an in-order read queue
// ------------
module mem_slave_model #(
  parameter int DW = 32
) (
  // Clock, reset and pacing
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic          slow,
  // Write channels
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic          wlast,
  output logic               bvalid,
  input  wire logic          bready,
  // Read channels
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [1:0]    arid,
  output logic               rvalid,
  input  wire logic          rready,
  output logic      [DW-1:0] rdata,
  output logic      [1:0]    rid,
  output logic               rlast
);
  logic [7:0] tick;
  logic [1:0] ids [4];
  logic [1:0] wp;
  logic [1:0] rp;
  logic [2:0] n;
  logic [4:0] beat;
  assign awready = !slow || tick[0];
  assign wready  = !slow || tick[1];
  assign arready = (n < 3'h4) && (!slow || tick[0]);
  assign rvalid  = (n != 3'h0) && (!slow || tick[1]);
  assign rid     = ids[rp];
  assign rlast   = beat == 5'h1f;
  assign rdata   = {(DW/8){tick}};
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tick   <= 8'h00;
      wp     <= 2'h0;
      rp     <= 2'h0;
      n      <= 3'h0;
      beat   <= 5'h00;
      bvalid <= 1'b0;
    end else begin
      tick <= tick + 8'h01;
      if (wvalid && wready && wlast) bvalid <= 1'b1;
      else if (bready) bvalid <= 1'b0;
      if (arvalid && arready) ids[wp] <= arid;
      if (arvalid && arready) wp <= wp + 2'h1;
      if (rvalid && rready) beat <= beat + 5'h01;
      if (rvalid && rready && rlast) rp <= rp + 2'h1;
      n <= n + 3'(arvalid && arready) - 3'(rvalid && rready && rlast);
    end
  end
endmodule // mem_slave_model

//--- bench/test_field_store_config_ctrl.sv
`timescale 1ns/1ns
module test_field_store_config_ctrl import fsc_pkg::*; ;
  localparam int DW = 32;
  logic ref_clk = 0, resetn = 0, regWr = 0, regRd = 0, frameEnd = 0, pixValid = 0, slow = 0;
  logic [7:0] regAddr = 0;
  logic [31:0] regWrData = 0, regRdData, awaddr, araddr, wdata, rdata, rdData, wd0, wd1, expAw;
  logic [6:0] evtIn = 0;
  logic [35:0] pixData = 0;
  logic [11:0] errData = 0;
  logic [10:0] cfgWidth, cfgHeight;
  logic [7:0] awlen, arlen;
  logic [3:0] wstrb;
  logic [2:0] awsize, arsize;
  logic [1:0] rdValid, cfgDepth, awburst, awid, arburst, arid, rid, pid;
  logic pixReady, deintEnable, motionEnable, forceBypass, updPending, irqOut, awvalid, awready;
  logic wvalid, wready, wlast, bvalid, bready, arvalid, arready, rvalid, rready, rlast, prv = 0;
  logic [31:0] pdat;
  int n_fail = 0, n_compared = 0, wIdx = 0, nBeat = 0, nB = 0, fed = 0;
  int oc [2] = '{0, 0};
  field_store_config_ctrl #(.DW(DW)) field_store_config_ctrl_i (.ref_clk, .resetn,
    .clkEn(1'b1), .regAddr, .regWrData, .regWr, .regRd, .regRdData, .frameEnd, .evtIn,
    .pixValid, .pixData, .errData, .pixReady, .rdValid, .rdData, .deintEnable, .motionEnable,
    .forceBypass, .cfgWidth, .cfgHeight, .cfgDepth, .updPending, .irqOut, .awvalid, .awready,
    .awaddr, .awlen, .awsize, .awburst, .awid, .wvalid, .wready, .wdata, .wstrb, .wlast,
    .bvalid, .bready, .arvalid, .arready, .araddr, .arlen, .arsize, .arburst, .arid, .rvalid,
    .rready, .rdata, .rid, .rlast);
  mem_slave_model #(.DW(DW)) mem_slave_model_i (.ref_clk, .resetn, .slow, .awvalid, .awready,
    .wvalid, .wready, .wlast, .bvalid, .bready, .arvalid, .arready, .arid, .rvalid, .rready,
    .rdata, .rid, .rlast);
  initial forever #4 ref_clk = ~ref_clk;
  // ------------
  // Shared tasks
  // ------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rchk(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("reg %h", a), e, regRdData);
  endtask
  task automatic fe;
    @(posedge ref_clk);
    frameEnd <= 1'b1;
    @(posedge ref_clk);
    frameEnd <= 1'b0;
    @(negedge ref_clk);
    if (motionEnable === 1'b1) wIdx = (wIdx + 1) % 3;
    expAw = 32'h1000 * (wIdx + 1);
  endtask
  function automatic logic [35:0] pxv(int i);
    return {3{12'(12'h5a1 + i)}};
  endfunction
  function automatic logic [11:0] erv(int i);
    return 12'hc30 ^ 12'(i);
  endfunction
  function automatic logic [47:0] pr(int i, logic [1:0] d);
    return d == DEP_12 ? {erv(i), pxv(i)} : {8'h00, 10'(erv(i)), 30'(pxv(i))};
  endfunction
  task automatic push(int i);
    int t;
    @(posedge ref_clk);
    pixValid <= 1'b1;
    pixData <= pxv(i);
    errData <= erv(i);
    @(negedge ref_clk);
    for (t = 0; t < 200 && pixReady !== 1'b1; t++) @(negedge ref_clk);
    if (t == 200) chk("pixReady", 1, 0);
    @(posedge ref_clk);
    pixValid <= 1'b0;
  endtask
  // ------------
  // Bus monitor
  // ------------
  always @(negedge ref_clk) if (resetn) begin
    fed <= frameEnd ? 0 : fed + 1;
    if (awvalid && awready) begin
      chk("awaddr", expAw, awaddr);
      chk("awctl", {awlen, awsize, awburst, awid}, {AXLEN_FIX, 3'h2, BURST_INCR, WR_ID});
      expAw += 32'h80;
    end
    if (wvalid && wready) begin
      if (nBeat == 0) wd0 = wdata;
      if (nBeat == 1) wd1 = wdata;
      chk("wlast", 32'(nBeat % 32 == 31), wlast);
      chk("wstrb", 4'hf, wstrb);
      nBeat++;
    end
    if (bvalid && bready) nB++;
    if (arvalid && arready) begin
      chk("arctl", {arlen, arsize, arburst}, {AXLEN_FIX, 3'h2, BURST_INCR});
      if (fed > 3) chk("arbuf", (wIdx + 2 - arid) % 3 + 1, araddr[31:12]);
      oc[arid[0]]++;
      chk("arout", 1, 32'(oc[arid[0]] <= 2));
    end
    if (rvalid && rlast) oc[rid[0]]--;
    chk("rdValid", prv ? 2'b01 << pid : 2'b00, rdValid);
    if (prv) chk("rdData", pdat, rdData);
    chk("rready", 1, rready);
    prv = rvalid;
    pid = rid;
    pdat = rdata;
  end
  // ------------
  // Scenarios
  // ------------
  task t_reset;
    rchk(OFS_CTRL, 0);
    rchk(OFS_STAT, 0);
    rchk(8'hfc, 0);
    chk("pixReady", 1, pixReady);
    $display("test reset done");
  endtask
  task t_update;
    wr(OFS_WIDTH, 32'h2d0);
    wr(OFS_HEIGHT, 32'hf0);
    wr(OFS_BUF0, 32'h1000);
    wr(OFS_BUF1, 32'h2000);
    wr(OFS_BUF2, 32'h3000);
    wr(OFS_BSIZE, 32'h40);
    wr(OFS_CTRL, 32'h7);
    rchk(OFS_STAT, 1);
    wr(OFS_WIDTH, 32'h100);
    rchk(OFS_WIDTH, 32'h2d0);
    chk("cfgWidth", 0, cfgWidth);
    wr(OFS_CTRL, 32'hb);
    chk("updPending", 0, updPending);
    rchk(OFS_ISR, 32'h2);
    wr(OFS_CTRL, 32'h7);
    fe();
    chk("cfg", {cfgWidth, cfgHeight}, {11'h2d0, 11'hf0});
    chk("modes", {deintEnable, motionEnable, forceBypass, updPending}, 4'hc);
    $display("test update done");
  endtask
  task t_simul;
    @(posedge ref_clk);
    regAddr <= OFS_IER;
    regWrData <= 32'h5;
    regWr <= 1'b1;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge ref_clk);
    chk("stalled", 0, regRdData);
    @(negedge ref_clk);
    chk("afterWrite", 32'h5, regRdData);
    $display("test simul done");
  endtask
  task automatic t_stream(logic [1:0] dep, int np, logic s);
    int k;
    int words;
    logic [95:0] two;
    words = dep == DEP_12 ? np * 3 / 2 : np * 5 / 4;
    slow <= s;
    wr(OFS_DEPTH, dep);
    wr(OFS_CTRL, 32'h7);
    fe();
    chk("cfgDepth", dep, cfgDepth);
    nBeat = 0;
    nB = 0;
    for (k = 0; k < np; k++) push(k);
    for (k = 0; k < 4000 && nB < words / 32; k++) @(posedge ref_clk);
    if (k == 4000) chk("timeout", 1, 0);
    chk("beats", words, nBeat);
    two = {48'h0, pr(0, dep)} | ({48'h0, pr(1, dep)} << (dep == DEP_12 ? 48 : 40));
    chk("word0", two[31:0], wd0);
    if (dep == DEP_12) chk("word1", two[63:32], wd1);
    else chk("word1", two[63:32], wd1);
    rchk(OFS_STAT, wIdx << 1);
    $display("test stream depth %0d done", dep);
  endtask
  task t_irq;
    wr(OFS_ISR, 32'h7ff);
    rchk(OFS_ISR, 0);
    wr(OFS_IER, 32'h10);
    @(posedge ref_clk);
    evtIn <= 7'h7f;
    @(posedge ref_clk);
    evtIn <= 7'h00;
    rchk(OFS_ISR, 32'h7f0);
    chk("irqOn", 1, irqOut);
    wr(OFS_ISR, 32'h10);
    rchk(OFS_ISR, 32'h7e0);
    chk("irqOff", 0, irqOut);
    $display("test irq done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_update();
    t_simul();
    t_stream(2'h2, 64, 1'b0);
    t_stream(2'h0, 128, 1'b1);
    t_stream(2'h1, 128, 1'b0);
    t_irq();
    complete_run();
  end
  initial begin
    #800000;
    chk("watchdog", 1, 0);
    complete_run();
  end
endmodule // test_field_store_config_ctrl
